// file: rtl/fefi_cfg.svh
// Constants of the fiber fault and media select block
`ifndef FEFI_CFG_SVH
`define FEFI_CFG_SVH
`define CLK_NS 4
`define LINK_PULSE_NS 16000000
`define FEFI_LAST_BIT 7'd84
`define FEFI_REP_LAST 2'd2
`define FEFI_MIN_BITS 9'd255
`define STRAP_LAST 2'd2
`define STRAP_WAIT 2'd3
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0c
`define CTL_FIBER 0
`define CTL_FCODE_EN 1
`define CTL_FORCE_PASS 2
`define CTL_LOOPBACK 3
`define CTL_DRIVE_HI 4
`define CTL_IRQ_EN 5
`define CTL_ADV_RF 6
`define STS_LINK 0
`define STS_SPEED100 1
`define STS_RF 2
`define STS_FEFI 3
`define STS_FULL_DUPLEX 4
`define STS_LP_RF 5
`define EV_LINK 0
`define EV_SPEED 1
`define EV_DUPLEX 2
`define EV_AN_DONE 3
`endif

// file: rtl/fefi_pkg.sv
// Types of the fiber fault and media select block
package fefi_pkg;
	typedef enum logic [1:0] {TX_SILENT, TX_IDLE, TX_DATA, TX_FEFI} tx_sel_t;
	typedef enum logic [1:0] {LNK_DOWN, LNK_BLOCKED, LNK_UP} lnk_t;
	typedef struct packed {
		logic sd_s1;
		logic sd_s2;
		logic pll_s1;
		logic pll_s2;
		logic [1:0] strap_cnt;
		logic [6:0] ctrl;
		lnk_t link;
		logic speed100;
		logic duplex;
		logic an_done_d;
		logic rf_lat;
		logic lp_rf;
		logic fefi_on;
		logic fefi_bit;
		logic [6:0] bit_cnt;
		logic [1:0] rep;
		logic [3:0] div;
		logic [31:0] lp_cnt;
		logic lp_pulse;
		tx_sel_t tx_sel;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic [31:0] prdata;
		logic pslverr;
	} state_t;
endpackage

// file: rtl/fiber_far_end_fault_media_select.sv
// Media select, fault reporting and far-end fault code generation
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "fefi_cfg.svh"

module fiber_far_end_fault_media_select #(
	parameter int BIT_DIV = 2,
	parameter int LP_CYCLES = `LINK_PULSE_NS / `CLK_NS
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic FIBER_SIGNAL_DETECT_PIN,
	input wire logic RX_PLL_LOCK,
	input wire logic RX_IDLE_SEEN,
	input wire logic RX_FEFI_SEEN,
	input wire logic AN_BUSY,
	input wire logic AN_DONE,
	input wire logic AN_PARTNER_RF,
	input wire logic RESOLVED_VALID,
	input wire logic RESOLVED_SPEED100,
	input wire logic RESOLVED_FULL_DUPLEX,
	input wire logic MII_TX_EN,
	output fefi_pkg::tx_sel_t TX_SEL,
	output logic TX_FEFI_BIT,
	output logic LINK_PULSE,
	output logic LINK_UP,
	output logic FIBER_MODE,
	output logic MII_SPEED100,
	output logic MII_FULL_DUPLEX,
	output logic MII_DRIVE_HI,
	output logic ADV_REMOTE_FAULT,
	output logic LP_REMOTE_FAULT,
	output logic IRQ,
	output logic STATUS_CHANGE_IRQ_PIN_N
);
	import fefi_pkg::*;

	// Refuse settings the counters cannot hold
	if (BIT_DIV < 1 || BIT_DIV > 15) begin : g_bad_div
		$error("BIT_DIV must be 1 to 15");
	end
	if (LP_CYCLES < 2) begin : g_bad_lp
		$error("LP_CYCLES must be at least 2");
	end

	localparam logic [3:0] DIV_LAST = 4'(BIT_DIV - 1);
	localparam logic [31:0] LP_LAST = 32'(LP_CYCLES - 1);

	state_t st_r; // All block state
	state_t st_nxt; // Next value of all state
	logic setup; // APB setup phase
	logic wr_acc; // APB write taking effect
	logic rd_acc; // APB read completing
	logic local_fault; // Fiber signal missing or PLL unlocked
	logic fefi_req; // Fault code wanted now
	logic bit_en; // One line bit time
	logic lp_rf_set; // Partner remote fault during negotiation
	logic [3:0] ev; // Interrupt events this cycle

	// Map a register offset to a legal flag
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `OFS_CTRL) || (a == `OFS_STATUS) ||
			(a == `OFS_IRQ_STAT) || (a == `OFS_IRQ_MASK);
	endfunction

	assign setup = PSEL && !PENABLE;
	assign wr_acc = PSEL && PENABLE && PWRITE && mapped(PADDR);
	assign rd_acc = PSEL && PENABLE && !PWRITE;
	assign local_fault = st_r.ctrl[`CTL_FIBER] && (!st_r.sd_s2 || !st_r.pll_s2);
	// Loopback keeps the code off so a local test sees real data
	assign fefi_req = st_r.ctrl[`CTL_FCODE_EN] && !st_r.ctrl[`CTL_LOOPBACK] &&
		local_fault;
	assign bit_en = (st_r.div == DIV_LAST);
	// Remote fault is a negotiation item, meaningless on fiber
	assign lp_rf_set = !st_r.ctrl[`CTL_FIBER] && AN_BUSY && AN_PARTNER_RF;

	// Next-state logic for the whole block
	always_comb begin
		st_nxt = st_r;
		ev = 4'h0;
		// Pin synchronisers; first stage only feeds second
		st_nxt.sd_s1 = FIBER_SIGNAL_DETECT_PIN;
		st_nxt.sd_s2 = st_r.sd_s1;
		st_nxt.pll_s1 = RX_PLL_LOCK;
		st_nxt.pll_s2 = st_r.pll_s1;
		// Strap sampled once synchronised signal detect is valid
		if (st_r.strap_cnt != `STRAP_WAIT) begin
			st_nxt.strap_cnt = st_r.strap_cnt + 2'd1;
			if (st_r.strap_cnt == `STRAP_LAST && st_r.sd_s2) begin
				st_nxt.ctrl[`CTL_FIBER] = 1'b1;
			end
		end
		// Register writes
		if (wr_acc) begin
			if (PADDR == `OFS_CTRL) begin
				st_nxt.ctrl = PWDATA[6:0];
			end else if (PADDR == `OFS_IRQ_MASK) begin
				st_nxt.irq_mask = PWDATA[3:0];
			end
		end
		// Read data captured at setup so the access edge sees it stable
		if (setup) begin
			st_nxt.pslverr = !mapped(PADDR);
			if (PADDR == `OFS_CTRL) begin
				st_nxt.prdata = {25'h0, st_r.ctrl};
			end else if (PADDR == `OFS_STATUS) begin
				st_nxt.prdata = {26'h0, st_r.lp_rf, st_r.duplex, st_r.fefi_on,
					st_r.rf_lat, st_r.speed100, st_r.link == LNK_UP};
			end else if (PADDR == `OFS_IRQ_STAT) begin
				st_nxt.prdata = {28'h0, st_r.irq_stat};
			end else if (PADDR == `OFS_IRQ_MASK) begin
				st_nxt.prdata = {28'h0, st_r.irq_mask};
			end else begin
				st_nxt.prdata = 32'h0;
			end
		end
		// Line bit divider
		st_nxt.div = bit_en ? 4'h0 : st_r.div + 4'h1;
		// Fault code engine; whole patterns only, at least three
		if (bit_en) begin
			if (!st_r.fefi_on) begin
				if (fefi_req) begin
					st_nxt.fefi_on = 1'b1;
					st_nxt.bit_cnt = 7'h0;
					st_nxt.rep = 2'h0;
				end
			end else if (st_r.bit_cnt == `FEFI_LAST_BIT) begin
				st_nxt.bit_cnt = 7'h0;
				if (st_r.rep != `FEFI_REP_LAST) begin
					st_nxt.rep = st_r.rep + 2'h1;
				end else if (!fefi_req) begin
					st_nxt.fefi_on = 1'b0;
				end
			end else begin
				st_nxt.bit_cnt = st_r.bit_cnt + 7'h1;
			end
		end
		// Ones until the last bit of each pattern, which is zero
		st_nxt.fefi_bit = st_nxt.fefi_on && (st_nxt.bit_cnt != `FEFI_LAST_BIT);
		// Link state
		if (st_r.ctrl[`CTL_FIBER]) begin
			case (st_r.link)
				LNK_DOWN: begin
					if (RX_FEFI_SEEN) begin
						st_nxt.link = LNK_BLOCKED;
					end else if (RX_IDLE_SEEN && !local_fault) begin
						st_nxt.link = LNK_UP;
					end
				end
				LNK_BLOCKED: begin
					// Only a local fault (signal missing or PLL unlocked) gives a fresh start
					if (local_fault) begin
						st_nxt.link = LNK_DOWN;
					end
				end
				LNK_UP: begin
					if ((local_fault || RX_FEFI_SEEN) && !st_r.ctrl[`CTL_FORCE_PASS]) begin
						st_nxt.link = LNK_DOWN;
					end
				end
				default: begin
					st_nxt.link = LNK_DOWN;
				end
			endcase
			st_nxt.speed100 = 1'b1;
		end else begin
			st_nxt.link = RESOLVED_VALID ? LNK_UP : LNK_DOWN;
			if (RESOLVED_VALID) begin
				st_nxt.speed100 = RESOLVED_SPEED100;
				st_nxt.duplex = RESOLVED_FULL_DUPLEX;
			end
		end
		// Remote fault flags; a set in the clearing cycle wins
		if (rd_acc && PADDR == `OFS_STATUS) begin
			st_nxt.rf_lat = st_r.rf_lat && !st_r.prdata[`STS_RF];
			st_nxt.lp_rf = st_r.lp_rf && !st_r.prdata[`STS_LP_RF];
		end
		if (local_fault || (st_r.ctrl[`CTL_FIBER] && RX_FEFI_SEEN) || lp_rf_set) begin
			st_nxt.rf_lat = 1'b1;
		end
		if (lp_rf_set) begin
			st_nxt.lp_rf = 1'b1;
		end
		// Status change events
		st_nxt.an_done_d = AN_DONE;
		ev[`EV_LINK] = (st_nxt.link == LNK_UP) != (st_r.link == LNK_UP);
		ev[`EV_SPEED] = st_nxt.speed100 != st_r.speed100;
		ev[`EV_DUPLEX] = st_nxt.duplex != st_r.duplex;
		ev[`EV_AN_DONE] = AN_DONE && !st_r.an_done_d;
		if (wr_acc && PADDR == `OFS_IRQ_STAT) begin
			st_nxt.irq_stat = st_r.irq_stat & ~PWDATA[3:0];
		end
		st_nxt.irq_stat = st_nxt.irq_stat | ev;
		// Transmit source selection
		if (st_nxt.fefi_on) begin
			st_nxt.tx_sel = TX_FEFI;
		end else if (st_nxt.ctrl[`CTL_FIBER] || st_nxt.speed100) begin
			// Continuous symbols: idle fills every gap
			st_nxt.tx_sel = (MII_TX_EN && st_nxt.link == LNK_UP) ? TX_DATA : TX_IDLE;
		end else begin
			st_nxt.tx_sel = (MII_TX_EN && st_nxt.link == LNK_UP) ? TX_DATA : TX_SILENT;
		end
		// Link pulse timer, only in 10M twisted-pair
		st_nxt.lp_pulse = 1'b0;
		if (!st_r.ctrl[`CTL_FIBER] && !st_r.speed100) begin
			if (st_r.lp_cnt >= LP_LAST) begin
				st_nxt.lp_cnt = 32'h0;
				st_nxt.lp_pulse = 1'b1;
			end else begin
				st_nxt.lp_cnt = st_r.lp_cnt + 32'h1;
			end
		end else begin
			st_nxt.lp_cnt = 32'h0;
		end
	end

	// State register
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign PRDATA = st_r.prdata;
	assign PREADY = 1'b1;
	assign PSLVERR = st_r.pslverr;
	assign TX_SEL = st_r.tx_sel;
	assign TX_FEFI_BIT = st_r.fefi_bit;
	assign LINK_PULSE = st_r.lp_pulse;
	assign LINK_UP = (st_r.link == LNK_UP);
	assign FIBER_MODE = st_r.ctrl[`CTL_FIBER];
	assign MII_SPEED100 = st_r.speed100;
	assign MII_FULL_DUPLEX = st_r.duplex;
	assign MII_DRIVE_HI = st_r.ctrl[`CTL_DRIVE_HI];
	assign ADV_REMOTE_FAULT = st_r.ctrl[`CTL_ADV_RF];
	assign LP_REMOTE_FAULT = st_r.lp_rf;
	assign IRQ = |(st_r.irq_stat & st_r.irq_mask);
	// Pin gated by its own enable; the level output is not
	assign STATUS_CHANGE_IRQ_PIN_N = !(st_r.ctrl[`CTL_IRQ_EN] && IRQ);

	// Bits sent in the current fault code run, for checking only
	logic [8:0] fefi_bits_r;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fefi_bits_r <= 9'h0;
		end else if (!st_r.fefi_on) begin
			fefi_bits_r <= 9'h0;
		end else if (bit_en && fefi_bits_r != 9'h1ff) begin
			fefi_bits_r <= fefi_bits_r + 9'h1;
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);

	property p_fcode_off;
		!st_r.fefi_on && !st_r.ctrl[`CTL_FCODE_EN] |=> !st_r.fefi_on;
	endproperty
	a_fcode_off: assert property (p_fcode_off) else $error("fault code began while disabled");

	property p_fcode_start;
		fefi_req && !st_r.fefi_on && bit_en |=> st_r.fefi_on ##1 st_r.tx_sel == TX_FEFI;
	endproperty
	a_fcode_start: assert property (p_fcode_start) else $error("fault code did not start");

	// The counter takes the last bit on the same edge that ends the run
	property p_three_reps;
		$fell(st_r.fefi_on) |-> fefi_bits_r >= `FEFI_MIN_BITS;
	endproperty
	a_three_reps: assert property (p_three_reps) else $error("fewer than three patterns");

	// Source select and code flag load on the same edge, so compare in one cycle
	property p_no_data_in_fcode;
		st_r.fefi_on |-> st_r.tx_sel == TX_FEFI;
	endproperty
	a_no_data_in_fcode: assert property (p_no_data_in_fcode) else $error("data during fault code");

	property p_fault_latch;
		local_fault |=> st_r.rf_lat [*2];
	endproperty
	a_fault_latch: assert property (p_fault_latch) else $error("status fault not latched");

	property p_read_clear;
		rd_acc && PADDR == `OFS_STATUS && st_r.prdata[`STS_RF] && !local_fault &&
			!RX_FEFI_SEEN && !lp_rf_set |=> !st_r.rf_lat;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear fault");

	property p_blocked;
		st_r.ctrl[`CTL_FIBER] && st_r.link == LNK_BLOCKED |=> st_r.link != LNK_UP;
	endproperty
	a_blocked: assert property (p_blocked) else $error("link up after fault pattern");

	property p_fault_drop;
		st_r.ctrl[`CTL_FIBER] && LINK_UP && local_fault && !st_r.ctrl[`CTL_FORCE_PASS]
			|=> !LINK_UP ##0 st_r.irq_stat[`EV_LINK];
	endproperty
	a_fault_drop: assert property (p_fault_drop) else $error("fault kept link up");

	property p_irq_pin;
		st_r.ctrl[`CTL_IRQ_EN] && st_r.irq_mask[`EV_LINK] && $changed(LINK_UP)
			|-> !STATUS_CHANGE_IRQ_PIN_N;
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not driven");

	property p_fcode_end;
		st_r.fefi_on && st_r.rep == `FEFI_REP_LAST && st_r.bit_cnt == `FEFI_LAST_BIT &&
			bit_en && !fefi_req |=> !st_r.fefi_on ##1 st_r.tx_sel != TX_FEFI;
	endproperty
	a_fcode_end: assert property (p_fcode_end) else $error("fault code did not stop");

	// Only the 10M twisted-pair timer may pulse; fiber and 100M never do
	property p_pulse_mode;
		st_r.lp_pulse |-> !$past(st_r.ctrl[`CTL_FIBER]) && !$past(st_r.speed100);
	endproperty
	a_pulse_mode: assert property (p_pulse_mode) else $error("pulse outside 10M pair");

	// Resolved speed reaches the MII one edge later in twisted pair
	property p_speed_follow;
		!st_r.ctrl[`CTL_FIBER] && RESOLVED_VALID |=> MII_SPEED100 == $past(RESOLVED_SPEED100);
	endproperty
	a_speed_follow: assert property (p_speed_follow) else $error("MII speed not resolved");

	// Drive strength follows the last control write
	property p_drive_hi;
		wr_acc && PADDR == `OFS_CTRL |=> MII_DRIVE_HI == $past(PWDATA[`CTL_DRIVE_HI]);
	endproperty
	a_drive_hi: assert property (p_drive_hi) else $error("drive strength not applied");

	// Continuous symbols at 100M: the line is never left silent
	property p_no_silence;
		st_r.speed100 && !st_r.fefi_on |-> st_r.tx_sel != TX_SILENT;
	endproperty
	a_no_silence: assert property (p_no_silence) else $error("silent line at 100M");

	// Main scenarios worth seeing in a run
	c_fcode: cover property ($rose(st_r.fefi_on));
	c_fiber_up: cover property (st_r.ctrl[`CTL_FIBER] && $rose(LINK_UP));
	c_rf_clear: cover property ($fell(st_r.rf_lat));
	c_irq: cover property ($fell(STATUS_CHANGE_IRQ_PIN_N));
	c_lp_rf: cover property ($rose(st_r.lp_rf));
endmodule // fiber_far_end_fault_media_select

// file: tb/fiber_far_end_fault_media_select_tb.sv
// Self-checking bench for the media select and fault block
`timescale 1ns/1ps
`include "fefi_cfg.svh"
module fiber_far_end_fault_media_select_tb;
	import fefi_pkg::*;
	logic SYS_CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, q;
	logic PREADY, PSLVERR, FIBER_SIGNAL_DETECT_PIN, RX_PLL_LOCK, RX_IDLE_SEEN, RX_FEFI_SEEN;
	logic AN_BUSY = 0, AN_DONE = 0, AN_PARTNER_RF = 0, MII_TX_EN = 0;
	logic RESOLVED_VALID = 0, RESOLVED_SPEED100 = 0, RESOLVED_FULL_DUPLEX = 0;
	logic LIGHT_ON = 1, SEND_FEFI = 0, err; // Partner commands
	tx_sel_t TX_SEL;
	logic TX_FEFI_BIT, LINK_PULSE, LINK_UP, FIBER_MODE, MII_SPEED100, MII_FULL_DUPLEX;
	logic MII_DRIVE_HI, ADV_REMOTE_FAULT, LP_REMOTE_FAULT, IRQ, STATUS_CHANGE_IRQ_PIN_N;
	int n_errors = 0, check_count = 0, cyc = 0, k;
	// Short bit and pulse periods keep the run brief
	fiber_far_end_fault_media_select #(.BIT_DIV(1), .LP_CYCLES(20))
		u_fiber_far_end_fault_media_select (
		.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR),
		.FIBER_SIGNAL_DETECT_PIN(FIBER_SIGNAL_DETECT_PIN), .RX_PLL_LOCK(RX_PLL_LOCK),
		.RX_IDLE_SEEN(RX_IDLE_SEEN), .RX_FEFI_SEEN(RX_FEFI_SEEN),
		.AN_BUSY(AN_BUSY), .AN_DONE(AN_DONE), .AN_PARTNER_RF(AN_PARTNER_RF),
		.RESOLVED_VALID(RESOLVED_VALID), .RESOLVED_SPEED100(RESOLVED_SPEED100),
		.RESOLVED_FULL_DUPLEX(RESOLVED_FULL_DUPLEX), .MII_TX_EN(MII_TX_EN),
		.TX_SEL(TX_SEL), .TX_FEFI_BIT(TX_FEFI_BIT), .LINK_PULSE(LINK_PULSE),
		.LINK_UP(LINK_UP), .FIBER_MODE(FIBER_MODE), .MII_SPEED100(MII_SPEED100),
		.MII_FULL_DUPLEX(MII_FULL_DUPLEX), .MII_DRIVE_HI(MII_DRIVE_HI),
		.ADV_REMOTE_FAULT(ADV_REMOTE_FAULT), .LP_REMOTE_FAULT(LP_REMOTE_FAULT),
		.IRQ(IRQ), .STATUS_CHANGE_IRQ_PIN_N(STATUS_CHANGE_IRQ_PIN_N)
	);
	fiber_module_model u_fiber_module_model (
		.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .LIGHT_ON(LIGHT_ON), .SEND_FEFI(SEND_FEFI),
		.FIBER_SIGNAL_DETECT_PIN(FIBER_SIGNAL_DETECT_PIN), .RX_PLL_LOCK(RX_PLL_LOCK),
		.RX_IDLE_SEEN(RX_IDLE_SEEN), .RX_FEFI_SEEN(RX_FEFI_SEEN)
	);
	always #2 SYS_CLK = ~SYS_CLK;
	// Hang guard
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end
	task automatic test_done();
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		PSEL <= 1;
		PENABLE <= 0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1;
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		q = PRDATA;
		err = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask
	// Bring fiber link up from idles
	task automatic fiber_up();
		LIGHT_ON <= 1;
		for (k = 0; k < 100 && LINK_UP !== 1'b1; k++) @(posedge SYS_CLK);
		chk(LINK_UP, 1);
		// A code run started while dark still finishes its whole patterns
		for (k = 0; k < 400 && TX_SEL === TX_FEFI; k++) @(posedge SYS_CLK);
	endtask
	// Dark fiber: three whole fault patterns, data held off, status and irq
	task automatic t_fault();
		apb(1, `OFS_CTRL, 32'h23);
		apb(1, `OFS_IRQ_MASK, 32'h1);
		apb(1, `OFS_IRQ_STAT, 32'hf);
		fiber_up();
		wait_cyc(1);
		chk(IRQ, 0);
		MII_TX_EN <= 1;
		LIGHT_ON <= 0;
		for (k = 0; k < 50 && TX_SEL !== TX_FEFI; k++) @(posedge SYS_CLK);
		for (int i = 0; i < 255; i++) begin
			chk(TX_FEFI_BIT, (i % 85 == 84) ? 0 : 1);
			chk(TX_SEL, TX_FEFI);
			@(posedge SYS_CLK);
		end
		chk(LINK_UP, 0);
		chk(IRQ, 1);
		chk(STATUS_CHANGE_IRQ_PIN_N, 0);
		apb(0, `OFS_STATUS, 0);
		chk(q & 32'hd, 32'hc);
		LIGHT_ON <= 1;
		for (k = 0; k < 400 && TX_SEL === TX_FEFI; k++) @(posedge SYS_CLK);
		wait_cyc(2);
		chk(TX_SEL, TX_DATA);
		apb(0, `OFS_STATUS, 0);
		apb(0, `OFS_STATUS, 0);
		chk(q & 32'hc, 32'h0);
		apb(1, `OFS_IRQ_STAT, 32'hf);
		wait_cyc(1);
		chk(IRQ, 0);
		MII_TX_EN <= 0;
	endtask
	// Fault pattern as first signal must not bring link up
	task automatic t_fefi_first();
		LIGHT_ON <= 0;
		wait_cyc(20);
		SEND_FEFI <= 1;
		LIGHT_ON <= 1;
		wait_cyc(50);
		chk(LINK_UP, 0);
		SEND_FEFI <= 0;
		LIGHT_ON <= 0;
		wait_cyc(20);
		fiber_up();
	endtask
	// Fault code disabled keeps idle, forced pass keeps link
	task automatic t_nocode_force();
		apb(1, `OFS_CTRL, 32'h05);
		AN_BUSY <= 1;
		AN_PARTNER_RF <= 1;
		LIGHT_ON <= 0;
		for (int i = 0; i < 40; i++) begin
			@(posedge SYS_CLK);
			chk(TX_SEL, TX_IDLE);
		end
		chk(LINK_UP, 1);
		chk(LP_REMOTE_FAULT, 0);
		AN_BUSY <= 0;
		AN_PARTNER_RF <= 0;
		fiber_up();
	endtask
	// Twisted pair: speed, idle/data, link pulses, drive, negotiation fault
	task automatic t_tp();
		apb(1, `OFS_CTRL, 32'h70);
		{RESOLVED_VALID, RESOLVED_SPEED100, RESOLVED_FULL_DUPLEX} <= 3'h7;
		wait_cyc(5);
		chk({FIBER_MODE, MII_DRIVE_HI, ADV_REMOTE_FAULT}, 3'h3);
		chk({LINK_UP, MII_SPEED100, MII_FULL_DUPLEX}, 3'h7);
		chk(TX_SEL, TX_IDLE);
		MII_TX_EN <= 1;
		wait_cyc(3);
		chk(TX_SEL, TX_DATA);
		MII_TX_EN <= 0;
		RESOLVED_SPEED100 <= 0;
		wait_cyc(3);
		chk({MII_SPEED100, TX_SEL}, {1'b0, TX_SILENT});
		for (k = 0; k < 45 && LINK_PULSE !== 1'b1; k++) @(posedge SYS_CLK);
		chk(LINK_PULSE, 1);
		AN_BUSY <= 1;
		AN_PARTNER_RF <= 1;
		wait_cyc(2);
		AN_BUSY <= 0;
		AN_PARTNER_RF <= 0;
		AN_DONE <= 1;
		wait_cyc(3);
		chk(LP_REMOTE_FAULT, 1);
		apb(0, `OFS_STATUS, 0);
		chk(q & 32'h24, 32'h24);
		apb(0, `OFS_IRQ_STAT, 0);
		chk(q & 32'h8, 32'h8);
		apb(0, 8'h10, 0);
		chk(err, 1);
		chk(q, 0);
		apb(1, `OFS_CTRL, 32'h01);
		wait_cyc(1);
		chk(FIBER_MODE, 1);
	endtask
	initial begin
		wait_cyc(12);
		ARST_N <= 1;
		wait_cyc(5);
		chk(FIBER_MODE, 1);
		t_fault();
		t_fefi_first();
		t_nocode_force();
		t_tp();
		test_done();
	end
endmodule // fiber_far_end_fault_media_select_tb

// file: tb/fiber_module_model.sv
// Behavioural optical module and receive front end seen by the block
`timescale 1ns/1ps
module fiber_module_model (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic LIGHT_ON,
	input wire logic SEND_FEFI,
	output logic FIBER_SIGNAL_DETECT_PIN,
	output logic RX_PLL_LOCK,
	output logic RX_IDLE_SEEN,
	output logic RX_FEFI_SEEN
);
	logic [2:0] lock_cnt; // Cycles of light seen so far
	// Detect follows light at once; the lock takes a while, so faults overlap
	assign FIBER_SIGNAL_DETECT_PIN = LIGHT_ON;
	assign RX_PLL_LOCK = lock_cnt == 3'h7;
	// Received pattern only means something once locked
	assign RX_IDLE_SEEN = RX_PLL_LOCK & ~SEND_FEFI;
	assign RX_FEFI_SEEN = RX_PLL_LOCK & SEND_FEFI;
	// Lock counter, lost on the first dark cycle
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			lock_cnt <= 3'h0;
		else if (!LIGHT_ON)
			lock_cnt <= 3'h0;
		else if (lock_cnt != 3'h7)
			lock_cnt <= lock_cnt + 3'h1;
	end
endmodule // fiber_module_model
